/* File: core/ios_seq_consts.vh */
`ifndef IOS_SEQ_CONSTS_VH
`define IOS_SEQ_CONSTS_VH

// Command codes of the held settings
`define IOS_CMD_UV_WARN 8'h58
`define IOS_CMD_UV_FAULT 8'h59
`define IOS_CMD_UV_RESP 8'h5A
`define IOS_CMD_PG_ON 8'h5E
`define IOS_CMD_TON_DLY 8'h60
`define IOS_CMD_TURN_ON_RAMP_TIME 8'h61
`define IOS_CMD_TOFF_DLY 8'h64

// Values held after reset
`define IOS_RST_UV_WARN 16'h0000
`define IOS_RST_UV_FAULT 16'h0000
`define IOS_RST_UV_RESP 8'h80
`define IOS_RST_PG_ON 16'h0000
`define IOS_RST_TON_DLY 16'h0003
`define IOS_RST_TURN_ON_RAMP_TIME 16'h0000
`define IOS_RST_TOFF_DLY 16'h0004

// Fault reaction byte fields
`define IOS_RESP_MODE_HI 7
`define IOS_RESP_MODE_LO 6
`define IOS_RETRY_CNT_HI 5
`define IOS_RETRY_CNT_LO 3
`define IOS_RETRY_TIME_HI 2
`define IOS_RETRY_TIME_LO 0
`define IOS_MODE_DIS_RETRY 2'h2
`define IOS_RETRY_NONE 3'h0
`define IOS_RETRY_FOREVER 3'h7

// Linear format fields
`define IOS_LIN_EXP_HI 15
`define IOS_LIN_EXP_LO 11
`define IOS_LIN_MANT_HI 10

// Timing
`define IOS_CLK_PERIOD_NS 5
`define IOS_MS_NS 1000000
`define IOS_RETRY_STEP_MS 16'h0023

`endif

/* File: core/ios_lin_ms.v */
`timescale 1ns/1ps
`include "ios_seq_consts.vh"

// Linear value (5-bit signed exponent, 11-bit signed mantissa) to whole
// milliseconds; negative values give zero, large values saturate.
module ios_lin_ms (
    input wire [15:0] lin_i, // Linear format time in ms
    output reg [15:0] ms_o   // Whole milliseconds
);
    wire signed [4:0] exp_w;
    wire [31:0] mant_w;
    reg [31:0] shl_w;
    reg [4:0] nexp_w;

    assign exp_w = lin_i[`IOS_LIN_EXP_HI:`IOS_LIN_EXP_LO];
    assign mant_w = {21'h000000, lin_i[`IOS_LIN_MANT_HI:0]};

    always @* begin
        shl_w = 32'h00000000;
        nexp_w = 5'h00;
        ms_o = 16'h0000;
        if (lin_i[`IOS_LIN_MANT_HI]) begin
            ms_o = 16'h0000;
        end else if (exp_w >= 0) begin
            shl_w = mant_w << exp_w[3:0];
            if (shl_w[31:16] != 16'h0000) begin
                ms_o = 16'hFFFF;
            end else begin
                ms_o = shl_w[15:0];
            end
        end else begin
            nexp_w = 5'h00 - exp_w;
            shl_w = mant_w >> nexp_w;
            ms_o = shl_w[15:0];
        end
    end
endmodule

/* File: core/ios_seq_top.v */
`timescale 1ns/1ps
`include "ios_seq_consts.vh"

module ios_seq_top #(
    parameter MS_CYCLES = `IOS_MS_NS / `IOS_CLK_PERIOD_NS
) (
    input wire core_clk_i,           // Clock, 200 MHz
    input wire rst_i,                // Asynchronous reset, active high
    input wire enable_i,             // Output enable request
    input wire soft_off_i,           // Soft-off ramp-down configured
    input wire uv_warn_i,            // Input below warning threshold
    input wire uv_fault_i,           // Input below fault threshold
    input wire clear_faults_i,       // Clear fault flags
    input wire [15:0] vout_i,        // Measured output voltage
    input wire cmd_valid_i,          // Command strobe
    input wire cmd_write_i,          // 1 write, 0 read
    input wire cmd_byte_i,           // 1 byte transfer, 0 word
    input wire [7:0] cmd_code_i,     // Command code
    input wire [15:0] cmd_wdata_i,   // Write data
    output reg rsp_valid_o,          // Answer strobe
    output reg rsp_err_o,            // Command refused
    output reg [15:0] rsp_data_o,    // Read data
    output reg [15:0] uv_warn_thr_o, // Warning threshold to comparator
    output reg [15:0] uv_fault_thr_o, // Fault threshold to comparator
    output reg out_en_o,             // Power stage enable
    output reg rise_o,               // Output ramp-up in progress
    output reg fall_soft_o,          // Soft ramp-down start pulse
    output reg power_good_output_o,  // Power good
    output reg alert_line_n_o,       // Alert, active low
    output reg uv_fault_flag_o,      // Under-voltage fault status bit
    output reg uv_warn_flag_o        // Under-voltage warning status bit
);
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_ONDLY = 3'h1;
    localparam [2:0] ST_RISE = 3'h2;
    localparam [2:0] ST_ON = 3'h3;
    localparam [2:0] ST_OFFDLY = 3'h4;
    localparam [2:0] ST_RETRY = 3'h5;
    localparam [2:0] ST_HOLD = 3'h6;
    localparam [31:0] MS_LAST = MS_CYCLES - 1;

    reg [7:0] resp_q;
    reg [15:0] pg_thr_q;
    reg [15:0] ton_dly_q;
    reg [15:0] turn_on_ramp_time_q;
    reg [15:0] toff_dly_q;
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [2:0] left_q;
    reg [2:0] left_d;
    reg [31:0] pre_q;
    reg [15:0] ms_q;
    reg [15:0] target_w;
    reg rd_ok_w;
    reg [15:0] rd_w;

    wire [15:0] ton_ms_w;
    wire [15:0] rise_ms_w;
    wire [15:0] toff_ms_w;
    wire [1:0] mode_w;
    wire [2:0] retry_cnt_w;
    wire [15:0] retry_ms_w;
    wire ms_tick_w;
    wire done_w;
    wire powered_w;
    wire fault_trip_w;
    wire wr_w;

    assign mode_w = resp_q[`IOS_RESP_MODE_HI:`IOS_RESP_MODE_LO];
    assign retry_cnt_w = resp_q[`IOS_RETRY_CNT_HI:`IOS_RETRY_CNT_LO];
    assign retry_ms_w = ({13'h0000, resp_q[`IOS_RETRY_TIME_HI:`IOS_RETRY_TIME_LO]}
        + 16'h0001) * `IOS_RETRY_STEP_MS;
    assign ms_tick_w = (pre_q == MS_LAST);
    assign done_w = (ms_q >= target_w);
    assign powered_w = (st_q == ST_ONDLY) || (st_q == ST_RISE) || (st_q == ST_ON)
        || (st_q == ST_OFFDLY);
    assign fault_trip_w = uv_fault_i && powered_w && (mode_w == `IOS_MODE_DIS_RETRY);
    assign wr_w = cmd_valid_i && cmd_write_i;

    ios_lin_ms u_ton (
        .lin_i(ton_dly_q),
        .ms_o(ton_ms_w)
    );

    ios_lin_ms u_rise (
        .lin_i(turn_on_ramp_time_q),
        .ms_o(rise_ms_w)
    );

    ios_lin_ms u_toff (
        .lin_i(toff_dly_q),
        .ms_o(toff_ms_w)
    );

    // Command decode; the fault reaction is the only byte-sized setting
    always @* begin
        rd_ok_w = 1'b1;
        rd_w = 16'h0000;
        case (cmd_code_i)
            `IOS_CMD_UV_WARN: begin
                rd_w = uv_warn_thr_o;
                rd_ok_w = !cmd_byte_i;
            end
            `IOS_CMD_UV_FAULT: begin
                rd_w = uv_fault_thr_o;
                rd_ok_w = !cmd_byte_i;
            end
            `IOS_CMD_UV_RESP: begin
                rd_w = {8'h00, resp_q};
                rd_ok_w = cmd_byte_i;
            end
            `IOS_CMD_PG_ON: begin
                rd_w = pg_thr_q;
                rd_ok_w = !cmd_byte_i;
            end
            `IOS_CMD_TON_DLY: begin
                rd_w = ton_dly_q;
                rd_ok_w = !cmd_byte_i;
            end
            `IOS_CMD_TURN_ON_RAMP_TIME: begin
                rd_w = turn_on_ramp_time_q;
                rd_ok_w = !cmd_byte_i;
            end
            `IOS_CMD_TOFF_DLY: begin
                rd_w = toff_dly_q;
                rd_ok_w = !cmd_byte_i;
            end
            default: begin
                rd_ok_w = 1'b0;
            end
        endcase
    end

    // Settings and answers
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_warn_thr_o <= `IOS_RST_UV_WARN;
            uv_fault_thr_o <= `IOS_RST_UV_FAULT;
            resp_q <= `IOS_RST_UV_RESP;
            pg_thr_q <= `IOS_RST_PG_ON;
            ton_dly_q <= `IOS_RST_TON_DLY;
            turn_on_ramp_time_q <= `IOS_RST_TURN_ON_RAMP_TIME;
            toff_dly_q <= `IOS_RST_TOFF_DLY;
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rsp_data_o <= 16'h0000;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            rsp_err_o <= cmd_valid_i && !rd_ok_w;
            rsp_data_o <= (cmd_valid_i && !cmd_write_i && rd_ok_w) ? rd_w : 16'h0000;
            if (wr_w && rd_ok_w) begin
                case (cmd_code_i)
                    `IOS_CMD_UV_WARN: begin
                        uv_warn_thr_o <= cmd_wdata_i;
                    end
                    `IOS_CMD_UV_FAULT: begin
                        uv_fault_thr_o <= cmd_wdata_i;
                    end
                    `IOS_CMD_UV_RESP: begin
                        resp_q <= cmd_wdata_i[7:0];
                    end
                    `IOS_CMD_PG_ON: begin
                        pg_thr_q <= cmd_wdata_i;
                    end
                    `IOS_CMD_TON_DLY: begin
                        ton_dly_q <= cmd_wdata_i;
                    end
                    `IOS_CMD_TURN_ON_RAMP_TIME: begin
                        turn_on_ramp_time_q <= cmd_wdata_i;
                    end
                    `IOS_CMD_TOFF_DLY: begin
                        toff_dly_q <= cmd_wdata_i;
                    end
                    default: begin
                        resp_q <= resp_q;
                    end
                endcase
            end
        end
    end

    // Wait length of the current state
    always @* begin
        case (st_q)
            ST_ONDLY: begin
                target_w = ton_ms_w;
            end
            ST_RISE: begin
                target_w = rise_ms_w;
            end
            ST_OFFDLY: begin
                target_w = toff_ms_w;
            end
            ST_RETRY: begin
                target_w = retry_ms_w;
            end
            default: begin
                target_w = 16'hFFFF;
            end
        endcase
    end

    // Sequencer
    always @* begin
        st_d = st_q;
        left_d = left_q;
        case (st_q)
            ST_OFF: begin
                if (enable_i) begin
                    st_d = ST_ONDLY;
                    left_d = retry_cnt_w;
                end
            end
            ST_ONDLY: begin
                if (done_w) begin
                    st_d = ST_RISE;
                end
            end
            ST_RISE: begin
                if (done_w) begin
                    st_d = ST_ON;
                end
            end
            ST_ON: begin
                st_d = ST_ON;
            end
            ST_OFFDLY: begin
                if (done_w) begin
                    st_d = ST_OFF;
                end
            end
            ST_RETRY: begin
                // restart only after the full interval
                if (!enable_i) begin
                    st_d = ST_OFF;
                end else if (done_w) begin
                    if (retry_cnt_w == `IOS_RETRY_FOREVER) begin
                        st_d = ST_ONDLY;
                    end else if (left_q != 3'h0) begin
                        left_d = left_q - 3'h1;
                        st_d = ST_ONDLY;
                    end else begin
                        st_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // stays off until the fault is cleared
                if (clear_faults_i && !uv_fault_i) begin
                    st_d = ST_OFF;
                end
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if ((st_q == ST_ONDLY) || (st_q == ST_RISE) || (st_q == ST_ON)) begin
            if (!enable_i) begin
                st_d = (toff_ms_w == 16'h0000) ? ST_OFF : ST_OFFDLY;
            end
        end
        if (fault_trip_w) begin
            // no retry goes straight to hold
            st_d = (retry_cnt_w == `IOS_RETRY_NONE) ? ST_HOLD : ST_RETRY;
        end
    end

    // Millisecond timer, restarted on every state change so a wait is never short
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= 32'h00000000;
            ms_q <= 16'h0000;
        end else if (st_d != st_q) begin
            pre_q <= 32'h00000000;
            ms_q <= 16'h0000;
        end else if (ms_tick_w) begin
            pre_q <= 32'h00000000;
            if (ms_q != 16'hFFFF) begin
                ms_q <= ms_q + 16'h0001;
            end
        end else begin
            pre_q <= pre_q + 32'h00000001;
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_OFF;
            left_q <= 3'h0;
        end else begin
            st_q <= st_d;
            left_q <= left_d;
        end
    end

    // Pin outputs, all registered from next state
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_en_o <= 1'b0;
            rise_o <= 1'b0;
            fall_soft_o <= 1'b0;
            power_good_output_o <= 1'b0;
        end else begin
            out_en_o <= (st_d == ST_RISE) || (st_d == ST_ON) || (st_d == ST_OFFDLY);
            rise_o <= (st_d == ST_RISE);
            // soft fall only after a nonzero delay
            fall_soft_o <= soft_off_i && (st_q == ST_OFFDLY) && (st_d == ST_OFF);
            power_good_output_o <= ((st_d == ST_RISE) || (st_d == ST_ON))
                && (vout_i >= pg_thr_q);
        end
    end

    // Status flags: an event in the clearing cycle keeps its flag set
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_fault_flag_o <= 1'b0;
            uv_warn_flag_o <= 1'b0;
            alert_line_n_o <= 1'b1;
        end else begin
            // fault bit and alert in every mode
            uv_fault_flag_o <= uv_fault_i || (uv_fault_flag_o && !clear_faults_i);
            uv_warn_flag_o <= uv_warn_i || (uv_warn_flag_o && !clear_faults_i);
            alert_line_n_o <= !(uv_fault_i || uv_warn_i
                || ((uv_fault_flag_o || uv_warn_flag_o) && !clear_faults_i));
        end
    end
endmodule

/* File: sim/ios_seq_top_properties.sv */
`timescale 1ns/1ps
module ios_seq_top_properties #(
    parameter MS_CYCLES = 4
) (
    input wire core_clk_i, // Clock
    input wire rst_i, // Reset
    input wire uv_warn_i, // Warn level
    input wire uv_fault_i, // Fault level
    input wire clear_faults_i, // Clear flags
    input wire soft_off_i, // Soft-off set
    input wire cmd_valid_i, // Command strobe
    input wire rsp_valid_o, // Answer strobe
    input wire rsp_err_o, // Refused
    input wire [15:0] rsp_data_o, // Read data
    input wire out_en_o, // Stage on
    input wire rise_o, // Ramp-up
    input wire fall_soft_o, // Soft fall pulse
    input wire alert_line_n_o, // Alert
    input wire uv_fault_flag_o // Fault flag
);
    default clocking dcb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_cmd;
        cmd_valid_i;
    endsequence
    sequence s_uv_hit;
        uv_fault_i && out_en_o;
    endsequence
    a_rsp_next_cycle:
        assert property (s_cmd |=> rsp_valid_o) else $error("no answer after command");
    a_rsp_has_cause:
        assert property (rsp_valid_o |-> $past(cmd_valid_i)) else $error("answer without command");
    a_err_no_data:
        assert property (rsp_err_o |-> rsp_valid_o && rsp_data_o == 16'h0000)
        else $error("refusal carries data");
    a_uv_alert_flag:
        assert property (s_uv_hit |=> !alert_line_n_o && uv_fault_flag_o)
        else $error("fault did not raise alert and flag");
    a_alert_has_cause:
        assert property ($fell(alert_line_n_o) |-> $past(uv_fault_i || uv_warn_i))
        else $error("alert without input fault");
    a_flag_held:
        assert property (uv_fault_flag_o && !clear_faults_i |=> uv_fault_flag_o)
        else $error("fault flag dropped without clear");
    a_soft_pulse:
        assert property (fall_soft_o |-> $past(soft_off_i) ##1 !fall_soft_o)
        else $error("bad soft fall pulse");
    a_rise_powered:
        assert property (rise_o |-> out_en_o) else $error("ramp without stage on");
endmodule

bind ios_seq_top ios_seq_top_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
    .core_clk_i, .rst_i, .uv_warn_i, .uv_fault_i, .clear_faults_i, .soft_off_i,
    .cmd_valid_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o, .out_en_o, .rise_o,
    .fall_soft_o, .alert_line_n_o, .uv_fault_flag_o
);

/* File: sim/ios_host_model.sv */
`timescale 1ns/1ps
`include "ios_seq_consts.vh"
module ios_host_model (
    input wire core_clk_i, // Clock
    output reg cmd_valid_o, // Command strobe
    output reg cmd_write_o, // 1 write
    output reg cmd_byte_o, // 1 byte
    output reg [7:0] cmd_code_o, // Code
    output reg [15:0] cmd_wdata_o, // Write data
    input wire rsp_valid_i, // Answer strobe
    input wire rsp_err_i, // Refused
    input wire [15:0] rsp_data_i // Read data
);
    reg [15:0] rdata = 16'h0000;
    reg err = 1'b0;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_byte_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    task xfer(input w, input b, input [7:0] code, input [15:0] wd);
        begin
            @(posedge core_clk_i);
            cmd_valid_o <= 1'b1;
            cmd_write_o <= w;
            cmd_byte_o <= b;
            cmd_code_o <= code;
            cmd_wdata_o <= wd;
            @(posedge core_clk_i);
            cmd_valid_o <= 1'b0;
            // Released code and data lines flip so stale fields cannot pass for fresh ones
            cmd_code_o <= ~code;
            cmd_wdata_o <= ~wd;
            @(posedge core_clk_i);
            err = rsp_valid_i ? rsp_err_i : 1'bx;
            rdata = rsp_valid_i ? rsp_data_i : 16'hDEAD;
        end
    endtask
    task acc(input w, input [7:0] code, input [15:0] wd);
        begin
            xfer(w, code == `IOS_CMD_UV_RESP, code, wd);
        end
    endtask
endmodule

/* File: sim/ios_seq_top_tb.sv */
`timescale 1ns/1ps
module ios_seq_top_tb;
    localparam MS = 4;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg enable_i = 1'b0;
    reg soft_off_i = 1'b0;
    reg uv_warn_i = 1'b0;
    reg uv_fault_i = 1'b0;
    reg clear_faults_i = 1'b0;
    reg [15:0] vout_i = 16'h0000;
    wire cmd_valid_i, cmd_write_i, cmd_byte_i, rsp_valid_o, rsp_err_o;
    wire [7:0] cmd_code_i;
    wire [15:0] cmd_wdata_i, rsp_data_o, uv_warn_thr_o, uv_fault_thr_o;
    wire out_en_o, rise_o, fall_soft_o, power_good_output_o, alert_line_n_o;
    wire uv_fault_flag_o, uv_warn_flag_o;
    integer n_mismatch = 0;
    integer total_checks = 0;
    integer n_soft = 0;
    integer i, k, t;
    reg [31:0] seed = 32'h23764989;
    reg [7:0] r;
    reg [2:0] rc;
    reg [23:0] e;
    reg [15:0] wv [0:6];

    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (fall_soft_o === 1'b1) begin
            n_soft = n_soft + 1;
        end
    end

    ios_seq_top #(.MS_CYCLES(MS)) uut (
        .core_clk_i, .rst_i, .enable_i, .soft_off_i, .uv_warn_i, .uv_fault_i,
        .clear_faults_i, .vout_i, .cmd_valid_i, .cmd_write_i, .cmd_byte_i, .cmd_code_i,
        .cmd_wdata_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o, .uv_warn_thr_o,
        .uv_fault_thr_o, .out_en_o, .rise_o, .fall_soft_o, .power_good_output_o,
        .alert_line_n_o, .uv_fault_flag_o, .uv_warn_flag_o
    );
    ios_host_model host (
        .core_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_byte_o(cmd_byte_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i),
        .rsp_valid_i(rsp_valid_o), .rsp_err_i(rsp_err_o), .rsp_data_i(rsp_data_o)
    );

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function integer retry_cyc(input [7:0] v);
        retry_cyc = (v[2:0] + 1) * 35 * MS;
    endfunction
    function [23:0] reg_tab(input integer n);
        case (n)
            0: reg_tab = {8'h58, 16'h0000};
            1: reg_tab = {8'h59, 16'h0000};
            2: reg_tab = {8'h5A, 16'h0080};
            3: reg_tab = {8'h5E, 16'h0000};
            4: reg_tab = {8'h60, 16'h0003};
            5: reg_tab = {8'h61, 16'h0000};
            default: reg_tab = {8'h64, 16'h0004};
        endcase
    endfunction

    task check(input [8*12-1:0] name, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task wait_sig(input sel, input lvl, input integer lim);
        begin
            t = 0;
            while ((sel ? rise_o : out_en_o) !== lvl && t < lim) begin
                @(posedge core_clk_i);
                t = t + 1;
            end
        end
    endtask
    // Leaves the stage off, flags cleared, then enables and waits for power
    task power_up;
        begin
            enable_i <= 1'b0;
            wait_sig(0, 0, 30 * MS);
            clear_faults_i <= 1'b1;
            @(posedge core_clk_i);
            clear_faults_i <= 1'b0;
            enable_i <= 1'b1;
            repeat (2) @(posedge core_clk_i);
            check("cleared", alert_line_n_o, 1);
            check("flag clear", uv_fault_flag_o, 0);
            wait_sig(0, 1, 30 * MS);
        end
    endtask

    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 7; i = i + 1) begin
            e = reg_tab(i);
            host.acc(0, e[23:16], 16'h0000);
            check("reset val", host.rdata, e[15:0]);
            seed = lfsr(seed);
            wv[i] = (i == 2) ? {8'h00, seed[7:0]} : seed[15:0];
            host.acc(1, e[23:16], wv[i]);
            check("write ok", host.err, 0);
            host.acc(0, e[23:16], 16'h0000);
            check("read back", host.rdata, wv[i]);
        end
        host.xfer(1, 1, 8'h58, 16'hA5A5);
        check("byte word", host.err, 1);
        host.xfer(1, 0, 8'h5A, 16'h0055);
        check("word byte", host.err, 1);
        host.xfer(1, 0, 8'h6F, 16'h0055);
        check("unknown", host.err, 1);
        check("warn thr", uv_warn_thr_o, wv[0]);
        check("fault thr", uv_fault_thr_o, wv[1]);
        host.acc(0, 8'h5A, 16'h0000);
        check("kept", host.rdata, wv[2]);
        host.acc(1, 8'h60, 16'h0003);
        host.acc(1, 8'h61, 16'h0002);
        host.acc(1, 8'h64, 16'h0004);
        host.acc(1, 8'h5E, 16'h0100);
        host.acc(1, 8'h5A, 16'h0000);
        vout_i <= 16'h0100;
        power_up;
        check("on delay", t >= 3 * MS - 1 && t <= 3 * MS + 3, 1);
        wait_sig(1, 0, 4 * MS);
        check("rise time", t >= 2 * MS - 1 && t <= 2 * MS + 2, 1);
        @(posedge core_clk_i);
        check("good at thr", power_good_output_o, 1);
        vout_i <= 16'h00FF;
        repeat (2) @(posedge core_clk_i);
        check("good below", power_good_output_o, 0);
        uv_warn_i <= 1'b1;
        uv_fault_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        check("warn flag", uv_warn_flag_o, 1);
        check("alert", alert_line_n_o, 0);
        check("fault flag", uv_fault_flag_o, 1);
        // Mode 00 only reports; the stage must keep running
        check("keeps on", out_en_o, 1);
        uv_warn_i <= 1'b0;
        uv_fault_i <= 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            rc = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'h0;
            seed = lfsr(seed);
            r = {2'b10, rc, seed[2:0]};
            host.acc(1, 8'h5A, {8'h00, r});
            power_up;
            for (k = 0; k < 2; k = k + 1) begin
                uv_fault_i <= 1'b1;
                @(posedge core_clk_i);
                uv_fault_i <= 1'b0;
                @(posedge core_clk_i);
                check("fault off", out_en_o, 0);
                check("fault flag", uv_fault_flag_o, 1);
                check("alert", alert_line_n_o, 0);
                wait_sig(0, 1, retry_cyc(r) + 5 * MS);
                check("restart", out_en_o, rc == 3'h7 || k < rc);
                if (out_en_o === 1'b1) begin
                    check("spacing", t >= retry_cyc(r) + 3 * MS - 2, 1);
                    check("spacing max", t <= retry_cyc(r) + 3 * MS + 3, 1);
                end
            end
        end
        power_up;
        soft_off_i <= 1'b1;
        enable_i <= 1'b0;
        wait_sig(0, 0, 8 * MS);
        check("off delay", t >= 4 * MS && t <= 4 * MS + 3, 1);
        host.acc(1, 8'h64, 16'h0000);
        check("soft fall", n_soft, 1);
        power_up;
        enable_i <= 1'b0;
        wait_sig(0, 0, 8 * MS);
        check("fast off", t <= 3, 1);
        repeat (2) @(posedge core_clk_i);
        check("no soft", n_soft, 1);
        print_verdict;
    end
endmodule
